// ### srsd_core.sv
// Subtract, rotate and sleep execution datapath with register port and file memory
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module srsd_core import srsd_pkg::*; #(
  parameter int WDT_PRE_W = 8, // Watchdog prescaler width
  parameter int FILE_DEPTH = 128 // Number of file registers
) (
  input wire logic ref_clk, // Core clock, 40 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [3:0] addr, // Register offset
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic wake_pin, // Asynchronous wake request
  output logic [15:0] rdata, // Read data, cycle after the read strobe
  output logic osc_stop, // Oscillator stop request, high while asleep
  output logic wdt_clr // One-cycle watchdog clear pulse
);
  localparam int FA_W = $clog2(FILE_DEPTH);

  typedef struct packed {
    logic [11:0] instr;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic pd;
    logic to;
    logic asleep;
    logic [FA_W-1:0] faddr;
    logic [WDT_PRE_W-1:0] wdt_pre;
    logic [7:0] wdt_cnt;
    logic wdt_clr;
    logic wake_s1;
    logic wake_s2;
    logic [15:0] rdata;
  } srsd_state_t;

  srsd_state_t st_q, st_d;
  logic [7:0] file_mem [FILE_DEPTH];
  logic mem_we;
  logic [FA_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  srsd_alu_in_t alu_in;
  srsd_alu_out_t alu_out;
  logic exec;
  logic [2:0] ex_op;
  logic ex_dest;
  logic [FA_W-1:0] ex_fa;
  logic [7:0] ex_opnd;
  logic [7:0] status_rd;
  logic pre_wrap;

  // Instruction fields come straight from the write data of an issue
  assign ex_op = wdata[SRSD_INS_OP_LSB +: 3];
  assign ex_dest = wdata[SRSD_INS_DEST_BIT];
  assign ex_opnd = wdata[SRSD_INS_OPND_LSB +: 8];
  assign ex_fa = ex_opnd[FA_W-1:0];
  // Issue is refused while asleep, since execution is halted
  assign exec = wr && (addr == SRSD_OFF_INSTR) && !st_q.asleep;

  // Operand fetch from the addressed file register
  always_comb begin
    alu_in.op = ex_op;
    alu_in.fval = file_mem[ex_fa];
    alu_in.lit = ex_opnd;
    alu_in.acc = st_q.acc;
    alu_in.carry = st_q.c;
  end

  srsd_alu u_alu (
    .alu_i(alu_in),
    .alu_o(alu_out)
  );

  // Status bits gathered for reads
  always_comb begin
    status_rd = 8'h00;
    status_rd[SRSD_ST_C] = st_q.c;
    status_rd[SRSD_ST_DC] = st_q.dc;
    status_rd[SRSD_ST_Z] = st_q.z;
    status_rd[SRSD_ST_PD] = st_q.pd;
    status_rd[SRSD_ST_TO] = st_q.to;
    status_rd[SRSD_ST_SLEEP] = st_q.asleep;
  end

  assign pre_wrap = &st_q.wdt_pre;

  // Next-state logic for the whole block
  always_comb begin
    st_d = st_q;
    mem_we = 1'b0;
    mem_wa = st_q.faddr;
    mem_wd = wdata[7:0];
    st_d.wdt_clr = 1'b0;
    st_d.rdata = 16'h0000;
    // Wake pin passes two flops before anything looks at it
    st_d.wake_s1 = wake_pin;
    st_d.wake_s2 = st_q.wake_s1;
    // Watchdog counts only while the oscillator runs
    if (!st_q.asleep) begin
      st_d.wdt_pre = st_q.wdt_pre + 1'b1;
      if (pre_wrap) begin
        st_d.wdt_cnt = st_q.wdt_cnt + 8'h01;
        // Count overflow marks a timeout
        if (&st_q.wdt_cnt) begin
          st_d.to = 1'b0;
        end
      end
    end else if (st_q.wake_s2) begin
      st_d.asleep = 1'b0;
    end
    // Register port writes
    if (wr) begin
      case (addr)
        SRSD_OFF_ACC: begin
          st_d.acc = wdata[7:0];
        end
        SRSD_OFF_STATUS: begin
          // Power-down and timeout flags are read-only to software
          st_d.c = wdata[SRSD_ST_C];
          st_d.dc = wdata[SRSD_ST_DC];
          st_d.z = wdata[SRSD_ST_Z];
        end
        SRSD_OFF_FADDR: begin
          st_d.faddr = wdata[FA_W-1:0];
        end
        SRSD_OFF_FDATA: begin
          mem_we = 1'b1;
        end
        default: begin
          st_d = st_d;
        end
      endcase
    end
    // Instruction execution
    if (exec) begin
      st_d.instr = wdata[11:0];
      mem_wa = ex_fa;
      mem_wd = alu_out.result;
      case (ex_op)
        SRSD_OP_RRC, SRSD_OP_FSUB, SRSD_OP_FSUBB: begin
          // Destination bit picks accumulator or file register
          if (ex_dest) begin
            mem_we = 1'b1;
          end else begin
            st_d.acc = alu_out.result;
          end
        end
        SRSD_OP_LSUB: begin
          st_d.acc = alu_out.result;
        end
        SRSD_OP_SLEEP: begin
          st_d.pd = 1'b0;
          st_d.to = 1'b1;
          st_d.wdt_cnt = SRSD_WDT_CLEAR;
          st_d.wdt_pre = '0;
          st_d.wdt_clr = 1'b1;
          st_d.asleep = 1'b1;
        end
        default: begin
          st_d.instr = wdata[11:0];
        end
      endcase
      // Rotate touches only carry; subtracts update all three
      if (alu_out.upd_carry) begin
        st_d.c = alu_out.carry;
      end
      if (alu_out.upd_arith) begin
        st_d.dc = alu_out.half_carry;
        st_d.z = alu_out.zero;
      end
    end
    // Read data stands only in the cycle after the strobe
    if (rd) begin
      case (addr)
        SRSD_OFF_INSTR: st_d.rdata = {4'h0, st_q.instr};
        SRSD_OFF_ACC: st_d.rdata = {8'h00, st_q.acc};
        SRSD_OFF_STATUS: st_d.rdata = {8'h00, status_rd};
        SRSD_OFF_FADDR: st_d.rdata = 16'(st_q.faddr);
        SRSD_OFF_FDATA: st_d.rdata = {8'h00, file_mem[st_q.faddr]};
        SRSD_OFF_WDT: st_d.rdata = {8'h00, st_q.wdt_cnt};
        default: st_d.rdata = 16'h0000;
      endcase
    end
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.acc <= SRSD_RST_ACC;
      st_q.pd <= SRSD_RST_PD;
      st_q.to <= SRSD_RST_TO;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // File memory is not reset; software initialises it
  always_ff @(posedge ref_clk) begin
    if (ce && nrst && mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  assign rdata = st_q.rdata;
  assign osc_stop = st_q.asleep;
  assign wdt_clr = st_q.wdt_clr;
endmodule

// ### srsd_alu.sv
// Shared constants and types, and the combinational subtract and rotate unit
`timescale 1ns/10ps
package srsd_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] SRSD_OFF_INSTR = 4'h0;
  localparam logic [3:0] SRSD_OFF_ACC = 4'h1;
  localparam logic [3:0] SRSD_OFF_STATUS = 4'h2;
  localparam logic [3:0] SRSD_OFF_FADDR = 4'h3;
  localparam logic [3:0] SRSD_OFF_FDATA = 4'h4;
  localparam logic [3:0] SRSD_OFF_WDT = 4'h5;
  // Instruction word field positions
  localparam int SRSD_INS_OPND_LSB = 0;
  localparam int SRSD_INS_DEST_BIT = 8;
  localparam int SRSD_INS_OP_LSB = 9;
  // Status register bit positions
  localparam int SRSD_ST_C = 0;
  localparam int SRSD_ST_DC = 1;
  localparam int SRSD_ST_Z = 2;
  localparam int SRSD_ST_PD = 3;
  localparam int SRSD_ST_TO = 4;
  localparam int SRSD_ST_SLEEP = 5;
  // Reset values, and the watchdog count loaded by sleep
  localparam logic [7:0] SRSD_RST_ACC = 8'h00;
  localparam logic SRSD_RST_PD = 1'b1;
  localparam logic SRSD_RST_TO = 1'b1;
  localparam logic [7:0] SRSD_WDT_CLEAR = 8'h00;
  // Decoded operation codes carried in the instruction word
  localparam logic [2:0] SRSD_OP_NOP = 3'h0;
  localparam logic [2:0] SRSD_OP_RRC = 3'h1;
  localparam logic [2:0] SRSD_OP_LSUB = 3'h2;
  localparam logic [2:0] SRSD_OP_FSUB = 3'h3;
  localparam logic [2:0] SRSD_OP_FSUBB = 3'h4;
  localparam logic [2:0] SRSD_OP_SLEEP = 3'h5;

  typedef struct packed {
    logic [2:0] op;
    logic [7:0] fval;
    logic [7:0] lit;
    logic [7:0] acc;
    logic carry;
  } srsd_alu_in_t;

  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic half_carry;
    logic zero;
    logic upd_carry;
    logic upd_arith;
  } srsd_alu_out_t;
endpackage

module srsd_alu import srsd_pkg::*; (
  input wire srsd_alu_in_t alu_i, // Operands and operation
  output srsd_alu_out_t alu_o // Result and flag updates
);
  // Minuend minus subtrahend with carry-in; carry out is the not-borrow
  function automatic logic [9:0] srsd_sub(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    srsd_sub = {low[4], full};
  endfunction

  logic [9:0] sub_r;

  // One subtractor serves all three subtract forms
  always_comb begin
    sub_r = 10'h000;
    alu_o = '0;
    case (alu_i.op)
      SRSD_OP_RRC: begin
        alu_o.result = {alu_i.carry, alu_i.fval[7:1]};
        alu_o.carry = alu_i.fval[0];
        alu_o.upd_carry = 1'b1;
      end
      SRSD_OP_LSUB: begin
        sub_r = srsd_sub(alu_i.lit, alu_i.acc, 1'b1);
        alu_o.upd_arith = 1'b1;
      end
      SRSD_OP_FSUB: begin
        sub_r = srsd_sub(alu_i.fval, alu_i.acc, 1'b1);
        alu_o.upd_arith = 1'b1;
      end
      SRSD_OP_FSUBB: begin
        // Carry set means no borrow, so it is the carry-in directly
        sub_r = srsd_sub(alu_i.fval, alu_i.acc, alu_i.carry);
        alu_o.upd_arith = 1'b1;
      end
      default: begin
        alu_o = '0;
      end
    endcase
    if (alu_o.upd_arith) begin
      alu_o.result = sub_r[7:0];
      alu_o.carry = sub_r[8];
      alu_o.half_carry = sub_r[9];
      alu_o.zero = (sub_r[7:0] == 8'h00);
      alu_o.upd_carry = 1'b1;
    end
  end
endmodule

// ### srsd_props.sv
// Port-level checker for the subtract, rotate and sleep datapath
`timescale 1ns/10ps
module srsd_props import srsd_pkg::*; (
  input wire logic ref_clk, // Core clock
  input wire logic nrst, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic [3:0] addr, // Register offset
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic wake_pin, // Wake request
  input wire logic [15:0] rdata, // Read data
  input wire logic osc_stop, // Oscillator stop
  input wire logic wdt_clr // Watchdog clear pulse
);
  logic sleep_iss;
  logic ins_wr;
  // Instruction writes seen on the register port
  assign ins_wr = ce && wr && addr == SRSD_OFF_INSTR;
  assign sleep_iss = ins_wr && wdata[11:9] == SRSD_OP_SLEEP;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_sleep_clr: assert property (sleep_iss && !osc_stop |=> wdt_clr)
    else $error("no watchdog clear after sleep");
  a_clr_once: assert property (wdt_clr && ce |=> !wdt_clr)
    else $error("watchdog clear longer than one cycle");
  a_clr_cause: assert property ($rose(wdt_clr) |-> $past(sleep_iss))
    else $error("watchdog clear without sleep");
  a_wdt_asleep: assert property (ce && rd && addr == SRSD_OFF_WDT && osc_stop |=> rdata == 16'h0000)
    else $error("watchdog count not zero asleep");
  a_sleep_stop: assert property (sleep_iss && !osc_stop |=> osc_stop)
    else $error("oscillator not stopped");
  a_stop_cause: assert property ($rose(osc_stop) |-> $past(sleep_iss))
    else $error("oscillator stopped without sleep");
  a_asleep_hold: assert property ((osc_stop && ce && !wake_pin) [*4] |=> osc_stop)
    else $error("sleep left without wake");
  a_asleep_halt: assert property (osc_stop && ins_wr |=> !wdt_clr)
    else $error("instruction executed asleep");
  a_sleep_flags: assert property (ce && rd && addr == SRSD_OFF_STATUS && osc_stop |=>
    rdata[SRSD_ST_PD] == 1'b0 && rdata[SRSD_ST_TO] == 1'b1)
    else $error("sleep status flags wrong");
  // Main scenarios reached
  c_sleep: cover property (sleep_iss && !osc_stop);
  c_wake: cover property ($fell(osc_stop));
  c_rd_asleep: cover property (rd && osc_stop);
endmodule

bind srsd_core srsd_props u_props (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .wake_pin(wake_pin), .rdata(rdata), .osc_stop(osc_stop),
  .wdt_clr(wdt_clr));

// ### srsd_core_test.sv
// Self-checking testbench for the subtract, rotate and sleep datapath
`timescale 1ns/10ps
module srsd_core_test import srsd_pkg::*; ();
  logic ref_clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, wake_pin = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic osc_stop, wdt_clr;
  int fail_count = 0, cmp_count = 0;
  // 40 MHz core clock
  always #12.5 ref_clk = ~ref_clk;
  srsd_core DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .wake_pin(wake_pin), .rdata(rdata), .osc_stop(osc_stop), .wdt_clr(wdt_clr));
  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle strobes, changed just after the edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Load operands, execute, and compare acc, file and flags with a reference
  task automatic run(input logic [2:0] op, input logic d, input logic [7:0] k, a, f,
    input logic [2:0] st);
    logic [8:0] r;
    logic [4:0] h;
    logic [2:0] es;
    logic [7:0] ea, ef;
    logic b;
    b = (op == SRSD_OP_FSUBB) ? !st[0] : 1'b0;
    r = (op == SRSD_OP_LSUB) ? {1'b0, k} - a : {1'b0, f} - a - b;
    h = (op == SRSD_OP_LSUB) ? {1'b0, k[3:0]} - a[3:0] : {1'b0, f[3:0]} - a[3:0] - b;
    es = {r[7:0] == 8'h00, !h[4], !r[8]};
    if (op == SRSD_OP_RRC) begin
      r[7:0] = {st[0], f[7:1]};
      es = {st[2:1], f[0]};
    end
    ea = (d && op != SRSD_OP_LSUB) ? a : r[7:0];
    ef = (d && op != SRSD_OP_LSUB) ? r[7:0] : f;
    wr_reg(SRSD_OFF_FADDR, {9'h000, k[6:0]});
    wr_reg(SRSD_OFF_FDATA, {8'h00, f});
    wr_reg(SRSD_OFF_ACC, {8'h00, a});
    wr_reg(SRSD_OFF_STATUS, {13'h0000, st});
    wr_reg(SRSD_OFF_INSTR, {4'h0, op, d, k});
    rd_chk(SRSD_OFF_ACC, {8'h00, ea});
    rd_chk(SRSD_OFF_FDATA, {8'h00, ef});
    rd_chk(SRSD_OFF_STATUS, {11'h000, 2'b11, es});
  endtask
  // Main sequence: arithmetic table, then sleep, refusal and wake
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    // Out of reset both power flags stand set and the arithmetic flags are clear
    rd_chk(SRSD_OFF_STATUS, 16'h0018);
    run(SRSD_OP_RRC, 1'b0, 8'h7F, 8'h11, 8'h35, 3'b111);
    run(SRSD_OP_RRC, 1'b1, 8'h00, 8'h11, 8'hA4, 3'b110);
    run(SRSD_OP_LSUB, 1'b1, 8'h10, 8'h10, 8'h33, 3'b000);
    run(SRSD_OP_LSUB, 1'b0, 8'h20, 8'h21, 8'h33, 3'b111);
    run(SRSD_OP_FSUB, 1'b0, 8'h05, 8'h19, 8'h48, 3'b000);
    run(SRSD_OP_FSUB, 1'b1, 8'h7F, 8'h06, 8'h05, 3'b001);
    run(SRSD_OP_FSUB, 1'b1, 8'h02, 8'h06, 8'h06, 3'b000);
    run(SRSD_OP_FSUBB, 1'b0, 8'h01, 8'h4F, 8'h50, 3'b000);
    run(SRSD_OP_FSUBB, 1'b1, 8'h7E, 8'h4F, 8'h50, 3'b001);
    wr_reg(SRSD_OFF_INSTR, {4'h0, SRSD_OP_SLEEP, 9'h000});
    #1 chk({14'h0000, osc_stop, wdt_clr}, 16'h0003);
    rd_chk(SRSD_OFF_STATUS, 16'h0031);
    rd_chk(SRSD_OFF_WDT, 16'h0000);
    wr_reg(SRSD_OFF_INSTR, {4'h0, SRSD_OP_LSUB, 9'h0FF});
    rd_chk(SRSD_OFF_ACC, 16'h004F);
    // A second sleep while asleep is refused as well, so no clear pulse follows
    wr_reg(SRSD_OFF_INSTR, {4'h0, SRSD_OP_SLEEP, 9'h000});
    #1 chk({15'h0000, wdt_clr}, 16'h0000);
    @(posedge ref_clk);
    wake_pin <= 1'b1;
    // Poll just after each edge, once the registered output has settled
    for (int i = 0; i < 20 && osc_stop === 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    wake_pin <= 1'b0;
    rd_chk(SRSD_OFF_STATUS, 16'h0011);
    // Prescaler restarted from zero, so the count first steps 256 awake cycles after wake
    repeat (250) @(posedge ref_clk);
    rd_chk(SRSD_OFF_WDT, 16'h0000);
    rd_chk(SRSD_OFF_WDT, 16'h0001);
    // With the clock enable low a write must leave no trace
    @(posedge ref_clk);
    ce <= 1'b0;
    wr_reg(SRSD_OFF_ACC, 16'h005A);
    ce <= 1'b1;
    rd_chk(SRSD_OFF_ACC, 16'h004F); // Frozen while ce was low
    end_sim;
  end
  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    fail_count++;
    end_sim;
  end
endmodule
